// [design/ohb_defs.vh]
// Constants for the OLED host bus interface
`ifndef OHB_DEFS_VH
`define OHB_DEFS_VH

// ----------------------------------------------------------------
// Bus modes, strap pattern {strap_a, strap_b}
// ----------------------------------------------------------------
`define OHB_MODE_SPI    2'h0
`define OHB_MODE_6800   2'h1
`define OHB_MODE_I2C    2'h2
`define OHB_MODE_8080   2'h3

// ----------------------------------------------------------------
// Synchronised pin vector layout
// ----------------------------------------------------------------
`define OHB_PIN_W       15
`define OHB_PIN_STRAP_A 14
`define OHB_PIN_STRAP_B 13
`define OHB_PIN_CS_N    12
`define OHB_PIN_INIT_N  11
`define OHB_PIN_DC      10
`define OHB_PIN_RW      9
`define OHB_PIN_EN      8
`define OHB_PIN_D_HI    7
`define OHB_PIN_D_LO    0

// ----------------------------------------------------------------
// Serial line positions on the data bus
// ----------------------------------------------------------------
`define OHB_SER_CLK     0
`define OHB_SER_DIN     1
`define OHB_SDA_OUT     2

// ----------------------------------------------------------------
// I2C byte phases
// ----------------------------------------------------------------
`define OHB_PH_ADDR     2'h0
`define OHB_PH_CTRL     2'h1
`define OHB_PH_DATA     2'h2
`define OHB_PH_IGN      2'h3

// ----------------------------------------------------------------
// Counts and field positions
// ----------------------------------------------------------------
`define OHB_BIT_LAST    4'h7
`define OHB_BIT_ACK     4'h8
`define OHB_CNT_ZERO    4'h0
`define OHB_CTRL_CO     7
`define OHB_CTRL_DC     6
`define OHB_RW_BIT      0
`define OHB_BUS_ALL     8'hFF
`define OHB_BUS_SDA     8'h04
`define OHB_BUS_NONE    8'h00
`define OHB_BYTE_ZERO   8'h00

`endif

// [design/ohb_sync.v]
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps

module ohb_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         sys_rst,
  // Pins and synchronised copy
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync
);

  reg [W-1:0] stage1_r;

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      stage1_r <= {W{1'b0}};
      pin_sync <= {W{1'b0}};
    end
    else
    begin
      stage1_r <= pin_in;
      pin_sync <= stage1_r;
    end
  end

endmodule // ohb_sync

// [design/ohb_host_port.v]
// Host bus port: 6800/8080 parallel, 4-wire serial and I2C front end
`timescale 1ns/1ps
`include "ohb_defs.vh"

// Summary of operation
// [RULE1] Straps 00 serial, 01 6800 parallel
// [RULE2] Straps 10 select I2C mode
// [RULE3] Straps 11 select 8080 parallel mode
// [RULE4] Bus activity honoured only with chip select low; the I2C path ignores chip select
// [RULE5] Low init pin restarts the interface
// [RULE6] Data/command pin high data, low command
// [RULE7] I2C uses data/command pin as address LSB
// [RULE8] 6800 read/write pin high read, low write
// [RULE9] 6800 enable high starts the access
// [RULE10] 8080 write strobe low starts a write
// [RULE11] 8080 read strobe low starts a read
// [RULE12] Host ties read/write and enable low serially
// [RULE13] Serial clock bit 0, data bit 1
// [RULE14] I2C clock bit 0, data bits 1 and 2
// [RULE15] Bidirectional 8-bit bus, driven only on reads; the code also drives bit 2 low during I2C acks
// [RULE16] Host ties unused data pins low
module ohb_host_port #(
  parameter [5:0] I2C_ADDR_BASE = 6'h2A  // Arbitrary value
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       sys_rst,
  // Straps and control pins
  input  wire       bus_select_strap_a,
  input  wire       bus_select_strap_b,
  input  wire       cs_n,
  input  wire       hw_init_n,
  input  wire       i2c_addr_lsb,
  input  wire       rw_sel,
  input  wire       en_rd_strobe,
  // Data bus pins
  input  wire [7:0] host_data_bus_i,
  output reg  [7:0] host_data_bus_o,
  output reg  [7:0] host_data_bus_oe,
  // Controller side
  output reg        cmd_valid,
  output reg  [7:0] cmd_byte,
  output reg        data_valid,
  output reg  [7:0] data_byte,
  output reg        rd_req,
  input  wire [7:0] rd_data,
  output reg        init_active,
  output reg  [1:0] bus_mode
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  wire [`OHB_PIN_W-1:0] pins_s;

  ohb_sync #(
    .W (`OHB_PIN_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .pin_in   ({bus_select_strap_a, bus_select_strap_b, cs_n, hw_init_n,
                i2c_addr_lsb, rw_sel, en_rd_strobe, host_data_bus_i}),
    .pin_sync (pins_s)
  );

  wire       cs_n_s   = pins_s[`OHB_PIN_CS_N];
  wire       init_n_s = pins_s[`OHB_PIN_INIT_N];
  wire       dc_s     = pins_s[`OHB_PIN_DC];
  wire       rw_s     = pins_s[`OHB_PIN_RW];
  wire       en_s     = pins_s[`OHB_PIN_EN];
  wire [7:0] d_s      = pins_s[`OHB_PIN_D_HI:`OHB_PIN_D_LO];
  wire       sck_s    = d_s[`OHB_SER_CLK];
  wire       sdi_s    = d_s[`OHB_SER_DIN];

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  reg        rw_q_r;
  reg        en_q_r;
  reg        sck_q_r;
  reg        sdi_q_r;
  reg        mode_ok_r;
  reg  [3:0] bit_cnt_r;
  reg  [7:0] shift_r;
  reg  [1:0] phase_r;
  reg        co_r;
  reg        dc_i2c_r;
  reg        ack_r;

  wire rst_any  = sys_rst | ~init_n_s;                 // RULE5
  wire sel      = ~cs_n_s;                             // RULE4
  wire rw_rise  = rw_s & ~rw_q_r;
  wire en_rise  = en_s & ~en_q_r;
  wire en_fall  = ~en_s & en_q_r;
  wire sck_rise = sck_s & ~sck_q_r;
  wire sck_fall = ~sck_s & sck_q_r;
  wire sda_fall = ~sdi_s & sdi_q_r & sck_s & sck_q_r;
  wire sda_rise = sdi_s & ~sdi_q_r & sck_s & sck_q_r;

  wire is_6800  = mode_ok_r & (bus_mode == `OHB_MODE_6800);
  wire is_8080  = mode_ok_r & (bus_mode == `OHB_MODE_8080);
  wire is_spi   = mode_ok_r & (bus_mode == `OHB_MODE_SPI);
  wire is_i2c   = mode_ok_r & (bus_mode == `OHB_MODE_I2C);

  // Parallel strobes: write takes data on the closing edge
  wire p_wr = sel & ((is_6800 & en_fall & ~rw_s)       // RULE8 RULE9
                   | (is_8080 & rw_rise));             // RULE10
  wire p_rd = sel & ((is_6800 & en_rise & rw_s)        // RULE8 RULE9
                   | (is_8080 & en_fall));             // RULE11
  wire p_drive = sel & ((is_6800 & en_s & rw_s)
                      | (is_8080 & ~en_s));            // RULE15

  wire [7:0] spi_byte  = {shift_r[6:0], sdi_s};
  wire       addr_hit  = (shift_r[7:1] == {I2C_ADDR_BASE, dc_s}); // RULE7
  wire       addr_wr   = ~shift_r[`OHB_RW_BIT];

  // ----------------------------------------------------------------
  // Mode capture and parallel / serial transfers
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst_any)
    begin
      rw_q_r           <= 1'b0;
      en_q_r           <= 1'b0;
      sck_q_r          <= 1'b0;
      sdi_q_r          <= 1'b0;
      mode_ok_r        <= 1'b0;
      bus_mode         <= `OHB_MODE_SPI;
      bit_cnt_r        <= `OHB_CNT_ZERO;
      shift_r          <= `OHB_BYTE_ZERO;
      phase_r          <= `OHB_PH_IGN;
      co_r             <= 1'b0;
      dc_i2c_r         <= 1'b0;
      ack_r            <= 1'b0;
      cmd_valid        <= 1'b0;
      cmd_byte         <= `OHB_BYTE_ZERO;
      data_valid       <= 1'b0;
      data_byte        <= `OHB_BYTE_ZERO;
      rd_req           <= 1'b0;
      host_data_bus_o  <= `OHB_BYTE_ZERO;
      host_data_bus_oe <= `OHB_BUS_NONE;
      init_active      <= 1'b1;                        // RULE5
    end
    else
    begin
      rw_q_r      <= rw_s;
      en_q_r      <= en_s;
      sck_q_r     <= sck_s;
      sdi_q_r     <= sdi_s;
      init_active <= 1'b0;
      cmd_valid   <= 1'b0;
      data_valid  <= 1'b0;
      rd_req      <= 1'b0;
      // Straps latched once after reset or init release
      if (!mode_ok_r)
      begin
        mode_ok_r <= 1'b1;
        bus_mode  <= {pins_s[`OHB_PIN_STRAP_A],
                      pins_s[`OHB_PIN_STRAP_B]};       // RULE1 RULE2 RULE3
      end
      // Parallel write and read
      if (p_wr)
      begin
        if (dc_s)                                      // RULE6
        begin
          data_valid <= 1'b1;
          data_byte  <= d_s;
        end
        else
        begin
          cmd_valid <= 1'b1;
          cmd_byte  <= d_s;
        end
      end
      if (p_rd)
      begin
        rd_req          <= 1'b1;
        host_data_bus_o <= rd_data;                    // RULE15
      end
      // 4-wire serial, MSB first on clock rise
      if (is_spi)
      begin
        if (!sel)
          bit_cnt_r <= `OHB_CNT_ZERO;                  // RULE4
        else if (sck_rise)                             // RULE13
        begin
          shift_r <= spi_byte;
          if (bit_cnt_r == `OHB_BIT_LAST)
          begin
            bit_cnt_r <= `OHB_CNT_ZERO;
            if (dc_s)                                  // RULE6
            begin
              data_valid <= 1'b1;
              data_byte  <= spi_byte;
            end
            else
            begin
              cmd_valid <= 1'b1;
              cmd_byte  <= spi_byte;
            end
          end
          else
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end
      // I2C slave, write direction
      if (is_i2c)
      begin
        if (sda_fall)                                  // RULE14
        begin
          bit_cnt_r <= `OHB_CNT_ZERO;
          phase_r   <= `OHB_PH_ADDR;
          ack_r     <= 1'b0;
        end
        else if (sda_rise)
        begin
          phase_r <= `OHB_PH_IGN;
          ack_r   <= 1'b0;
        end
        else if (sck_rise)
        begin
          if (bit_cnt_r == `OHB_BIT_ACK)
            bit_cnt_r <= `OHB_CNT_ZERO;
          else
          begin
            shift_r   <= {shift_r[6:0], sdi_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        end
        else if (sck_fall)
        begin
          if (bit_cnt_r == `OHB_CNT_ZERO)
            ack_r <= 1'b0;
          else if (bit_cnt_r == `OHB_BIT_ACK && !ack_r)
          begin
            case (phase_r)
              `OHB_PH_ADDR:
              begin
                ack_r   <= addr_hit & addr_wr;
                phase_r <= (addr_hit & addr_wr) ? `OHB_PH_CTRL
                                                : `OHB_PH_IGN;
              end
              `OHB_PH_CTRL:
              begin
                ack_r    <= 1'b1;
                co_r     <= shift_r[`OHB_CTRL_CO];
                dc_i2c_r <= shift_r[`OHB_CTRL_DC];
                phase_r  <= `OHB_PH_DATA;
              end
              `OHB_PH_DATA:
              begin
                ack_r <= 1'b1;
                if (dc_i2c_r)                          // RULE6
                begin
                  data_valid <= 1'b1;
                  data_byte  <= shift_r;
                end
                else
                begin
                  cmd_valid <= 1'b1;
                  cmd_byte  <= shift_r;
                end
                if (co_r)
                  phase_r <= `OHB_PH_CTRL;
              end
              default:
                ack_r <= 1'b0;
            endcase
          end
        end
      end
      // Output enables: whole bus on reads, SDA low on ack
      if (p_drive)
        host_data_bus_oe <= `OHB_BUS_ALL;              // RULE15
      else if (is_i2c & ack_r)
        host_data_bus_oe <= `OHB_BUS_SDA;              // RULE14
      else
        host_data_bus_oe <= `OHB_BUS_NONE;
      if (is_i2c)
        host_data_bus_o <= `OHB_BYTE_ZERO;
    end
  end

endmodule // ohb_host_port

// [verif/ohb_chk_assertions.sv]
// Port checker for the OLED host bus interface
`timescale 1ns/1ps
module ohb_chk (
  // Clock and reset
  input wire       sys_clk,
  input wire       sys_rst,
  // Pins
  input wire       bus_select_strap_a,
  input wire       bus_select_strap_b,
  input wire       cs_n,
  input wire       hw_init_n,
  input wire       i2c_addr_lsb,
  input wire       rw_sel,
  input wire       en_rd_strobe,
  input wire [7:0] host_data_bus_o,
  input wire [7:0] host_data_bus_oe,
  // Controller side
  input wire       cmd_valid,
  input wire       data_valid,
  input wire       rd_req,
  input wire       init_active,
  input wire [1:0] bus_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_mode_latch: assert property ($fell(init_active) |->
    bus_mode == {bus_select_strap_a, bus_select_strap_b})
    else $error("bus mode differs from straps");
  a_init_pin: assert property (!hw_init_n [*3] |=> init_active)
    else $error("init pin ignored");
  a_oe_legal: assert property (host_data_bus_oe == 8'h00 ||
    host_data_bus_oe == 8'hFF || host_data_bus_oe == 8'h04)
    else $error("bad output enable");
  a_oe_par: assert property (host_data_bus_oe == 8'hFF |-> bus_mode[0])
    else $error("bus driven outside parallel mode");
  a_sda_drive: assert property (host_data_bus_oe == 8'h04 |->
    bus_mode == 2'h2 && host_data_bus_o == 8'h00)
    else $error("bad data line drive");
  a_cs_guard: assert property (cs_n [*5] ##0 bus_mode != 2'h2 |->
    !cmd_valid && !data_valid && !rd_req)
    else $error("activity without chip select");
  a_dc_route: assert property ((cmd_valid || data_valid) &&
    bus_mode != 2'h2 |-> data_valid == $past(i2c_addr_lsb, 3))
    else $error("byte routed wrongly");
  a_wr_6800: assert property (bus_mode == 2'h1 && !cs_n && !rw_sel &&
    $fell(en_rd_strobe) |-> ##[2:4] (cmd_valid || data_valid))
    else $error("6800 write lost");
  a_rd_6800: assert property (bus_mode == 2'h1 && !cs_n && rw_sel &&
    $rose(en_rd_strobe) |-> ##[2:4] rd_req)
    else $error("6800 read lost");
  a_wr_8080: assert property (bus_mode == 2'h3 && !cs_n &&
    $rose(rw_sel) |-> ##[2:4] (cmd_valid || data_valid))
    else $error("8080 write lost");
  a_rd_8080: assert property (bus_mode == 2'h3 && !cs_n &&
    $fell(en_rd_strobe) |-> ##[2:4] rd_req)
    else $error("8080 read lost");
endmodule // ohb_chk

bind ohb_host_port ohb_chk u_chk (.sys_clk, .sys_rst, .bus_select_strap_a,
  .bus_select_strap_b, .cs_n, .hw_init_n, .i2c_addr_lsb, .rw_sel,
  .en_rd_strobe, .host_data_bus_o, .host_data_bus_oe, .cmd_valid,
  .data_valid, .rd_req, .init_active, .bus_mode);

// [verif/ohb_host_model.sv]
// Host microcontroller model driving the display bus pins
`timescale 1ns/1ps
module ohb_host_model (
  // Clock
  input  wire       sys_clk,
  // Pins toward the device
  output reg        cs_n,
  output reg        dc,
  output reg        rw_sel,
  output reg        en_rd_strobe,
  output wire [7:0] bus_i,
  input  wire [7:0] bus_o,
  input  wire [7:0] bus_oe
);
  reg [7:0] bus_r;
  reg       i2c_r;
  reg       sda_r;
  reg       scl_r;
  wire      sda_w;
  // Pulled-up data line, device pulls low on bit 2
  assign sda_w = sda_r & ~(bus_oe[2] & ~bus_o[2]);
  assign bus_i = i2c_r ? {5'h00, sda_w, sda_w, scl_r} : bus_r;
  initial
  begin
    {cs_n, dc, rw_sel, en_rd_strobe} = 4'h8;
    {bus_r, i2c_r, sda_r, scl_r} = 11'h003;
  end
  task tk(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task par(input [1:0] m, input c, input rw, input [7:0] d, input off);
    begin
      rw_sel <= m[1] | rw;
      en_rd_strobe <= m[1];
      tk(3);
      cs_n <= off;
      dc <= c;
      bus_r <= d;
      tk(3);
      if (!m[1]) en_rd_strobe <= 1'h1;
      else if (rw) en_rd_strobe <= 1'h0;
      else rw_sel <= 1'h0;
      tk(4);
      en_rd_strobe <= m[1];
      rw_sel <= m[1] | rw;
      tk(4);
      cs_n <= 1'h1;
      tk(2);
    end
  endtask
  task spi(input c, input [7:0] d, input integer n);
    integer i;
    begin
      {rw_sel, en_rd_strobe} <= 2'h0;
      cs_n <= 1'h0;
      dc <= c;
      for (i = 7; i > 7 - n; i = i - 1)
      begin
        bus_r <= {6'h00, d[i], 1'h0};
        tk(3);
        bus_r[0] <= 1'h1;
        tk(3);
      end
      bus_r <= 8'h00;
      tk(6);
      cs_n <= 1'h1;
      tk(3);
    end
  endtask
  task ibit(input b);
    begin
      sda_r <= b;
      tk(3);
      scl_r <= 1'h1;
      tk(3);
      scl_r <= 1'h0;
      tk(1);
    end
  endtask
  task ibyte(input [7:0] d, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        ibit(d[i]);
      sda_r <= 1'h1;
      tk(3);
      scl_r <= 1'h1;
      tk(2);
      ack = ~sda_w;
      tk(1);
      scl_r <= 1'h0;
      tk(1);
    end
  endtask
  task istart(input c);
    begin
      {rw_sel, en_rd_strobe, cs_n} <= 3'h0;
      dc <= c;
      {i2c_r, sda_r, scl_r} <= 3'h7;
      tk(4);
      sda_r <= 1'h0;
      tk(4);
      scl_r <= 1'h0;
      tk(2);
    end
  endtask
  task istop;
    begin
      sda_r <= 1'h0;
      tk(3);
      scl_r <= 1'h1;
      tk(3);
      sda_r <= 1'h1;
      tk(4);
    end
  endtask
endmodule // ohb_host_model

// [verif/ohb_host_port_tb.sv]
// Self-checking testbench for the OLED host bus interface
`timescale 1ns/1ps
module ohb_host_port_tb;
  localparam [5:0] ADDR = 6'h15; // Arbitrary address
  reg        sys_clk, sys_rst, strap_a, strap_b, hw_init_n, ack;
  reg  [7:0] rd_data, seen, d;
  reg  [1:0] nm;
  wire       cs_n, dc, rw_sel, en, cmd_valid, data_valid, rd_req, init_active;
  wire [7:0] bus_i, bus_o, bus_oe, cmd_byte, data_byte;
  wire [1:0] bus_mode;
  integer    seed, err_total, compares, ncmd, ndat, nrd, m, i, k;
  ohb_host_port #(.I2C_ADDR_BASE(ADDR)) uut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .bus_select_strap_a(strap_a),
    .bus_select_strap_b(strap_b), .cs_n(cs_n), .hw_init_n(hw_init_n),
    .i2c_addr_lsb(dc), .rw_sel(rw_sel), .en_rd_strobe(en),
    .host_data_bus_i(bus_i), .host_data_bus_o(bus_o),
    .host_data_bus_oe(bus_oe), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .data_valid(data_valid), .data_byte(data_byte), .rd_req(rd_req),
    .rd_data(rd_data), .init_active(init_active), .bus_mode(bus_mode));
  ohb_host_model u_host (.sys_clk(sys_clk), .cs_n(cs_n), .dc(dc),
    .rw_sel(rw_sel), .en_rd_strobe(en), .bus_i(bus_i), .bus_o(bus_o),
    .bus_oe(bus_oe));
  initial
  begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (!sys_rst)
    begin
      ncmd <= ncmd + cmd_valid;
      ndat <= ndat + data_valid;
      nrd <= nrd + rd_req;
      if (bus_oe == 8'hFF) seen <= bus_o;
    end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Expected pulse count for one byte on one route
  function [7:0] f_cnt(input want, input off);
    f_cnt = {7'h00, want & ~off};
  endfunction
  task test_done;
    begin
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task rst_mode(input [1:0] md);
    begin
      {strap_a, strap_b, sys_rst} <= {md, 1'h1};
      u_host.tk(20);
      sys_rst <= 1'h0;
      u_host.tk(4);
      chk(bus_mode, md);
    end
  endtask
  task xfer(input [1:0] md, input cc, input [7:0] dd, input off);
    integer k0, k1;
    begin
      k0 = ncmd;
      k1 = ndat;
      if (md[0]) u_host.par(md, cc, 1'h0, dd, off);
      else u_host.spi(cc, dd, off ? 4 : 8);
      chk(ndat - k1, f_cnt(cc, off));
      chk(ncmd - k0, f_cnt(~cc, off));
      if (!off) chk(cc ? data_byte : cmd_byte, dd);
    end
  endtask
  task prd(input [1:0] md);
    begin
      k = nrd;
      rd_data <= $random(seed);
      u_host.par(md, 1'h1, 1'h1, 8'h00, 1'h0);
      chk(nrd - k, 8'h01);
      chk(seen, rd_data);
    end
  endtask
  initial
  begin
    {seed, err_total, compares, ncmd, ndat, nrd} = {32'h3C2AA4A3, 160'h0};
    {sys_rst, strap_a, strap_b, hw_init_n, rd_data, seen} = 20'h90000;
    for (m = 0; m < 4; m = m + 1)
      if (m != 2)
      begin
        rst_mode(m);
        for (i = 0; i < 8; i = i + 1)
          xfer(m, $random(seed), i == 0 ? 8'h00 : i == 1 ? 8'hFF :
               $random(seed), i == 3 || (i > 3 && $random(seed) % 6 == 0));
        if (m != 0) prd(m);
        if (m != 0) prd(m);
        $display("test mode %0d done", m);
      end
    rst_mode(2);
    k = ndat;
    d = $random(seed);
    u_host.istart(1'h1);
    u_host.ibyte({ADDR, 2'h2}, ack);
    chk(ack, 8'h01);
    u_host.ibyte(8'h40, ack);
    chk(ack, 8'h01);
    u_host.ibyte(d, ack);
    u_host.istop;
    chk(ndat - k, 8'h01);
    chk(data_byte, d);
    u_host.istart(1'h0);
    u_host.ibyte({ADDR, 2'h2}, ack);
    u_host.istop;
    chk(ack, 8'h00);
    $display("test i2c done");
    // Straps move mid-run: mode holds until the next init
    nm = $random(seed);
    {strap_a, strap_b} <= nm;
    u_host.tk(6);
    chk(bus_mode, 8'h02);
    hw_init_n <= 1'h0;
    u_host.tk(5);
    chk(init_active, 8'h01);
    hw_init_n <= 1'h1;
    u_host.tk(6);
    chk(bus_mode, nm);
    $display("test init done");
    test_done;
  end
  initial
  begin
    u_host.tk(90000);
    err_total = err_total + 1;
    test_done;
  end
endmodule // ohb_host_port_tb
